// file: hdl/prf_pkg.sv
// Purpose: shared constants of the pulse ratio follower
// Assumes: 32-bit register bus with byte addresses, one word per register
// Notes:   factors are signed Q16.16 on the bus, held internally as 17-bit signed
package prf_pkg;
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_HALF_FACTOR = 8'h04;
    localparam logic [7:0]  OFS_GEAR_FACTOR = 8'h08;
    localparam logic [7:0]  OFS_IO_SETUP    = 8'h0c;
    localparam logic [7:0]  OFS_PRIM_CNT    = 8'h10;
    localparam logic [7:0]  OFS_FOLLOW_CNT  = 8'h14;
    localparam logic [7:0]  OFS_ALT_CNT     = 8'h18;
    localparam logic [7:0]  OFS_SEC_CNT     = 8'h1c;
    localparam logic [7:0]  OFS_ERR_CODE    = 8'h20;
    localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h24;
    localparam logic [7:0]  OFS_IRQ_CLEAR   = 8'h28;
    localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h2c;
    localparam logic [7:0]  OFS_IO_STATUS   = 8'h30;
    localparam int          CTRL_HALF_BIT   = 0;
    localparam int          CTRL_GEAR_BIT   = 1;
    localparam int          FRAC_W          = 16;
    localparam int          FACT_W          = 17;
    localparam logic [16:0] FACTOR_RST      = 17'h00000;
    localparam logic [31:0] FACTOR_LO_LIM   = 32'hffff0000;
    localparam logic [31:0] FACTOR_HI_LIM   = 32'h00010000;
    localparam logic [15:0] ERR_NONE        = 16'h0000;
    localparam logic [15:0] ERR_RATIO_RANGE = 16'h232c;
    localparam int          IOS_CHAN_LSB    = 0;
    localparam int          IOS_FUNC_LSB    = 8;
    localparam int          IOS_CLK_LSB     = 24;
    localparam int          IOS_RATIO_BIT   = 28;
    localparam logic [7:0]  FIRST_CHAN      = 8'h0d;
    localparam logic [7:0]  LAST_CHAN       = 8'h12;
    localparam logic [7:0]  FUNC_BASE       = 8'h0a;
    localparam int          NUM_CH          = 6;
    localparam logic [3:0]  CLK_NONE        = 4'h0;
    localparam logic [3:0]  CLK_QUAD_IN     = 4'h1;
    localparam logic [3:0]  CLK_STEP_OUT    = 4'h2;
    localparam logic [3:0]  CLK_STEPDIR_IN  = 4'h3;
    localparam logic [1:0]  PAIR_13_14      = 2'h0;
    localparam logic [1:0]  PAIR_15_16      = 2'h1;
    localparam logic [1:0]  PAIR_17_18      = 2'h2;
    localparam logic [1:0]  PAIR_NONE       = 2'h3;
    localparam int          IRQ_W           = 3;
    localparam int          IRQ_RANGE_ERR   = 0;
    localparam int          IRQ_PRIM_STEP   = 1;
    localparam int          IRQ_FOLLOW      = 2;
endpackage : prf_pkg

// file: hdl/prf_pulse_decode.sv
// Purpose: turns a follower pin pair into single-cycle count pulses with direction
// Assumes: pins are asynchronous to clk
// Notes:   quadrature is decoded x4; otherwise a is step (rising edge) and b is direction
`timescale 1ns/10ps
`default_nettype none
module prf_pulse_decode (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // pins and mode
    input  wire logic pin_a,
    input  wire logic pin_b,
    input  wire logic quad_mode,
    // decoded count
    output logic      step_pulse,
    output logic      step_dir
);
    logic [1:0] meta_ff;
    logic [1:0] sync_ff;
    logic [1:0] last_ff;
    logic       nxt_pulse;
    logic       nxt_dir;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 2'h0;
            sync_ff <= 2'h0;
            last_ff <= 2'h0;
        end else begin
            meta_ff <= {pin_b, pin_a};
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    // a single-bit change is one quadrature count; a double change is noise and dropped
    always_comb begin
        nxt_pulse = 1'b0;
        nxt_dir   = 1'b0;
        if (quad_mode) begin
            if ((sync_ff ^ last_ff) == 2'h1 || (sync_ff ^ last_ff) == 2'h2) begin
                nxt_pulse = 1'b1;
                nxt_dir   = sync_ff[0] ^ last_ff[1];
            end
        end else begin
            nxt_pulse = sync_ff[0] & ~last_ff[0];
            nxt_dir   = sync_ff[1];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            step_pulse <= 1'b0;
            step_dir   <= 1'b0;
        end else begin
            step_pulse <= nxt_pulse;
            step_dir   <= nxt_dir;
        end
    end
endmodule : prf_pulse_decode
`default_nettype wire

// file: hdl/prf_ratio_scale.sv
// Purpose: scales a pulse stream by a signed fraction of magnitude below one
// Assumes: in_pulse is a single-cycle strobe from the clk domain
// Notes:   the remainder is kept, so the long-run ratio has no drift
`timescale 1ns/10ps
`default_nettype none
module prf_ratio_scale
    import prf_pkg::*;
(
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    // control
    input  wire logic                    enable,
    input  wire logic [prf_pkg::FACT_W-1:0] factor,
    // input stream
    input  wire logic                    in_pulse,
    input  wire logic                    in_dir,
    // scaled stream
    output logic                         out_pulse,
    output logic                         out_dir
);
    logic [FRAC_W-1:0] acc_ff;
    logic [FRAC_W-1:0] mag;
    logic [FRAC_W:0]   nxt_sum;

    always_comb begin
        mag     = factor[FACT_W-1] ? FRAC_W'(-factor) : factor[FRAC_W-1:0];
        nxt_sum = {1'b0, acc_ff} + {1'b0, mag};
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_ff    <= '0;
            out_pulse <= 1'b0;
            out_dir   <= 1'b0;
        end else if (!enable) begin
            acc_ff    <= '0;
            out_pulse <= 1'b0;
        end else begin
            out_pulse <= in_pulse & nxt_sum[FRAC_W];
            if (in_pulse) begin
                acc_ff  <= nxt_sum[FRAC_W-1:0];
                out_dir <= in_dir ^ factor[FACT_W-1];
            end
        end
    end
endmodule : prf_ratio_scale
`default_nettype wire

// file: hdl/prf_follower.sv
// Purpose: electronic gearing: half-axis follower and secondary axis ratio drive
// Assumes: core step/dir arrive on clk; channel pins 13..18 are asynchronous
// Notes:   registers on Avalon-MM, every access answers on its second cycle
`timescale 1ns/10ps
`default_nettype none
module prf_follower
    import prf_pkg::*;
(
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      arst_n,
    // avalon-mm slave
    input  wire logic [prf_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    output logic [31:0]                    avs_readdata,
    output logic                           avs_waitrequest,
    // primary axis from the motion core
    input  wire logic                      core_step,
    input  wire logic                      core_dir,
    // primary axis to the drive
    output logic                           prim_step,
    output logic                           prim_dir,
    // channel pins 13..18, index 0 is channel 13
    input  wire logic [prf_pkg::NUM_CH-1:0] io_in,
    output logic [prf_pkg::NUM_CH-1:0]     io_out,
    output logic [prf_pkg::NUM_CH-1:0]     io_oe,
    // interrupt
    output logic                           irq
);
    import prf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic ratio_ok(input logic [31:0] v);
        return ($signed(v) > $signed(FACTOR_LO_LIM)) && ($signed(v) < $signed(FACTOR_HI_LIM));
    endfunction : ratio_ok

    function automatic logic [3:0] pair_role(input logic [3:0] clk_a, input logic [3:0] clk_b,
                                             input logic ok_a, input logic ok_b);
        return (ok_a && ok_b && clk_a == clk_b) ? clk_a : CLK_NONE;
    endfunction : pair_role

    function automatic logic [31:0] count_step(input logic [31:0] c, input logic dir);
        return dir ? c - 32'h1 : c + 32'h1;
    endfunction : count_step

    ////////////////////////////////////////////////////////////////////////////
    logic                  ack_ff;
    logic                  wr_go;
    logic                  rd_go;
    logic [1:0]            ctrl_ff;
    logic [FACT_W-1:0]     half_fac_ff;
    logic [FACT_W-1:0]     gear_fac_ff;
    logic [3:0]            ch_clk_ff [NUM_CH];
    logic [NUM_CH-1:0]     ch_ok_ff;
    logic [31:0]           prim_cnt_ff;
    logic [31:0]           follow_cnt_ff;
    logic [31:0]           alt_cnt_ff;
    logic [31:0]           sec_cnt_ff;
    logic [15:0]           err_code_ff;
    logic [IRQ_W-1:0]      irq_sts_ff;
    logic [IRQ_W-1:0]      irq_en_ff;
    logic [3:0]            role [3];
    logic [1:0]            fol_sel;
    logic [1:0]            out_sel;
    logic                  fol_pulse;
    logic                  fol_dir;
    logic                  half_pulse;
    logic                  half_dir;
    logic                  nxt_prim_pulse;
    logic                  nxt_prim_dir;
    logic                  sec_pulse;
    logic                  sec_dir;
    logic                  range_rej;
    logic [IRQ_W-1:0]      irq_evt;
    logic [7:0]            ios_chan;
    logic [2:0]            ios_idx;

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle keeps read data a plain register
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign wr_go           = avs_write & ack_ff;
    assign rd_go           = avs_read & ~ack_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read | avs_write) & ~ack_ff;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= 32'h0;
        end else if (rd_go) begin
            unique case (avs_address)
                OFS_CTRL:        avs_readdata <= {30'h0, ctrl_ff};
                OFS_HALF_FACTOR: avs_readdata <= {{(32 - FACT_W){half_fac_ff[FACT_W-1]}}, half_fac_ff};
                OFS_GEAR_FACTOR: avs_readdata <= {{(32 - FACT_W){gear_fac_ff[FACT_W-1]}}, gear_fac_ff};
                OFS_PRIM_CNT:    avs_readdata <= prim_cnt_ff;
                OFS_FOLLOW_CNT:  avs_readdata <= follow_cnt_ff;
                OFS_ALT_CNT:     avs_readdata <= alt_cnt_ff;
                OFS_SEC_CNT:     avs_readdata <= sec_cnt_ff;
                OFS_ERR_CODE:    avs_readdata <= {16'h0, err_code_ff};
                OFS_IRQ_STATUS:  avs_readdata <= {29'h0, irq_sts_ff};
                OFS_IRQ_ENABLE:  avs_readdata <= {29'h0, irq_en_ff};
                OFS_IO_STATUS:   avs_readdata <= {20'h0, fol_sel, out_sel, 2'h0, ch_ok_ff};
                default:         avs_readdata <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    assign range_rej = wr_go && (avs_address == OFS_HALF_FACTOR || avs_address == OFS_GEAR_FACTOR)
                       && !ratio_ok(avs_writedata);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_ff     <= 2'h0;
            half_fac_ff <= FACTOR_RST;
            gear_fac_ff <= FACTOR_RST;
            irq_en_ff   <= '0;
        end else if (wr_go) begin
            if (avs_address == OFS_CTRL) begin
                ctrl_ff <= avs_writedata[1:0];
            end
            if (avs_address == OFS_HALF_FACTOR && !range_rej) begin
                half_fac_ff <= avs_writedata[FACT_W-1:0];
            end
            if (avs_address == OFS_GEAR_FACTOR && !range_rej) begin
                gear_fac_ff <= avs_writedata[FACT_W-1:0];
            end
            if (avs_address == OFS_IRQ_ENABLE) begin
                irq_en_ff <= avs_writedata[IRQ_W-1:0];
            end
        end
    end

    // a refused factor keeps the old value and latches the range error code
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            err_code_ff <= ERR_NONE;
        end else if (range_rej) begin
            err_code_ff <= ERR_RATIO_RANGE;
        end else if (wr_go && avs_address == OFS_ERR_CODE) begin
            err_code_ff <= ERR_NONE;
        end
    end

    // channel setup: a channel joins a pair only with its own function code and ratio mode
    assign ios_chan = avs_writedata[IOS_CHAN_LSB +: 8];
    assign ios_idx  = 3'(ios_chan - FIRST_CHAN);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ch_ok_ff <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                ch_clk_ff[i] <= CLK_NONE;
            end
        end else if (wr_go && avs_address == OFS_IO_SETUP
                     && ios_chan >= FIRST_CHAN && ios_chan <= LAST_CHAN) begin
            ch_clk_ff[ios_idx] <= avs_writedata[IOS_CLK_LSB +: 4];
            ch_ok_ff[ios_idx]  <= avs_writedata[IOS_RATIO_BIT]
                                  && {4'h0, avs_writedata[IOS_FUNC_LSB +: 4]} == ios_chan - FUNC_BASE;
        end
    end

    always_comb begin
        for (int p = 0; p < 3; p++) begin
            role[p] = pair_role(ch_clk_ff[2*p], ch_clk_ff[2*p+1], ch_ok_ff[2*p], ch_ok_ff[2*p+1]);
        end
        fol_sel = PAIR_NONE;
        for (int p = 2; p >= 0; p--) begin
            if (role[p] == CLK_QUAD_IN || role[p] == CLK_STEPDIR_IN) begin
                fol_sel = 2'(p);
            end
        end
        if (role[1] == CLK_STEP_OUT) begin
            out_sel = PAIR_15_16;
        end else if (role[0] == CLK_STEP_OUT) begin
            out_sel = PAIR_13_14;
        end else begin
            out_sel = PAIR_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // follower input and the two scalers
    prf_pulse_decode u_decode (
        .clk        (clk),
        .arst_n     (arst_n),
        .pin_a      (fol_sel == PAIR_NONE ? 1'b0 : io_in[{fol_sel, 1'b0}]),
        .pin_b      (fol_sel == PAIR_NONE ? 1'b0 : io_in[{fol_sel, 1'b1}]),
        .quad_mode  (fol_sel != PAIR_NONE && role[fol_sel] == CLK_QUAD_IN),
        .step_pulse (fol_pulse),
        .step_dir   (fol_dir)
    );

    prf_ratio_scale u_half (
        .clk       (clk),
        .arst_n    (arst_n),
        .enable    (ctrl_ff[CTRL_HALF_BIT]),
        .factor    (half_fac_ff),
        .in_pulse  (fol_pulse),
        .in_dir    (fol_dir),
        .out_pulse (half_pulse),
        .out_dir   (half_dir)
    );

    // in half-axis mode the core's own steps are ignored: the follower owns the axis
    assign nxt_prim_pulse = ctrl_ff[CTRL_HALF_BIT] ? half_pulse : core_step;
    assign nxt_prim_dir   = ctrl_ff[CTRL_HALF_BIT] ? half_dir : core_dir;

    prf_ratio_scale u_gear (
        .clk       (clk),
        .arst_n    (arst_n),
        .enable    (ctrl_ff[CTRL_GEAR_BIT]),
        .factor    (gear_fac_ff),
        .in_pulse  (nxt_prim_pulse),
        .in_dir    (nxt_prim_dir),
        .out_pulse (sec_pulse),
        .out_dir   (sec_dir)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs: secondary step on the pair's first channel, direction on its second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prim_step <= 1'b0;
            prim_dir  <= 1'b0;
            io_out    <= '0;
            io_oe     <= '0;
        end else begin
            prim_step <= nxt_prim_pulse;
            prim_dir  <= nxt_prim_dir;
            io_out    <= '0;
            io_oe     <= '0;
            if (out_sel != PAIR_NONE) begin
                io_out[{out_sel, 1'b0}] <= sec_pulse;
                io_out[{out_sel, 1'b1}] <= sec_dir;
                io_oe[{out_sel, 1'b0}]  <= 1'b1;
                io_oe[{out_sel, 1'b1}]  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counters: a software write loads the counter and wins over a count that cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prim_cnt_ff   <= 32'h0;
            follow_cnt_ff <= 32'h0;
            alt_cnt_ff    <= 32'h0;
            sec_cnt_ff    <= 32'h0;
        end else begin
            if (wr_go && avs_address == OFS_PRIM_CNT) begin
                prim_cnt_ff <= avs_writedata;
            end else if (nxt_prim_pulse) begin
                prim_cnt_ff <= count_step(prim_cnt_ff, nxt_prim_dir);
            end
            if (wr_go && avs_address == OFS_FOLLOW_CNT) begin
                follow_cnt_ff <= avs_writedata;
            end else if (fol_pulse) begin
                follow_cnt_ff <= count_step(follow_cnt_ff, fol_dir);
            end
            if (wr_go && avs_address == OFS_ALT_CNT) begin
                alt_cnt_ff <= avs_writedata;
            end else if (fol_pulse && fol_sel == PAIR_15_16) begin
                alt_cnt_ff <= alt_cnt_ff + 32'h1;
            end
            if (wr_go && avs_address == OFS_SEC_CNT) begin
                sec_cnt_ff <= avs_writedata;
            end else if (sec_pulse) begin
                sec_cnt_ff <= count_step(sec_cnt_ff, sec_dir);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: a new event in the clearing cycle stays set
    assign irq_evt = {fol_pulse, nxt_prim_pulse, range_rej};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_sts_ff <= '0;
        end else if (wr_go && avs_address == OFS_IRQ_CLEAR) begin
            irq_sts_ff <= (irq_sts_ff & ~avs_writedata[IRQ_W-1:0]) | irq_evt;
        end else begin
            irq_sts_ff <= irq_sts_ff | irq_evt;
        end
    end

    assign irq = |(irq_sts_ff & irq_en_ff);

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_half_gate_off: assert property (!ctrl_ff[CTRL_HALF_BIT] |=> !half_pulse)
        else $error("half-axis pulse while disabled");
    chk_factor_range: assert property (half_fac_ff != 17'h10000 && gear_fac_ff != 17'h10000)
        else $error("stored factor reached minus one");
    chk_half_pulse_cause: assert property (half_pulse |-> $past(fol_pulse) && $past(ctrl_ff[CTRL_HALF_BIT]))
        else $error("half-axis pulse without follower input");
    // with a factor of one half the carry comes exactly when the remainder already holds a half
    chk_gear_half: assert property (ctrl_ff[CTRL_GEAR_BIT] && gear_fac_ff == 17'h08000 && nxt_prim_pulse
                                    |=> sec_pulse == $past(u_gear.acc_ff[FRAC_W-1]))
        else $error("half ratio secondary step wrong");
    chk_zero_factor: assert property (half_fac_ff == 17'h00000 && $stable(half_fac_ff) |=> !half_pulse)
        else $error("pulse out with zero factor");
    chk_range_error: assert property (range_rej |=> err_code_ff == ERR_RATIO_RANGE && irq_sts_ff[IRQ_RANGE_ERR]
                                      && $stable(half_fac_ff) && $stable(gear_fac_ff))
        else $error("refused factor not reported");
    chk_alt_count: assert property (fol_pulse && fol_sel == PAIR_15_16 && !wr_go |=> alt_cnt_ff == $past(alt_cnt_ff) + 32'h1)
        else $error("third counter missed a raw pulse");
    chk_alt_idle: assert property (fol_sel == PAIR_17_18 && !wr_go |=> $stable(alt_cnt_ff))
        else $error("third counter moved on pair 17/18");
    chk_follow_count: assert property (fol_pulse && !wr_go |=> follow_cnt_ff != $past(follow_cnt_ff))
        else $error("follower counter missed a pulse");
    chk_gear_gate: assert property (!ctrl_ff[CTRL_GEAR_BIT] |=> !sec_pulse ##1 !io_out[0] && !io_out[2])
        else $error("secondary step while gearing disabled");
    chk_dir_sign: assert property (half_pulse |-> half_dir == ($past(fol_dir) ^ $past(half_fac_ff[FACT_W-1])))
        else $error("primary direction ignores factor sign");

    cov_half_step: cover property (ctrl_ff[CTRL_HALF_BIT] && half_pulse);
    cov_gear_step: cover property (ctrl_ff[CTRL_GEAR_BIT] && sec_pulse && out_sel == PAIR_15_16);
    cov_range_rej: cover property (range_rej);
endmodule : prf_follower
`default_nettype wire

// file: verification/prf_quad_src.sv
// Purpose: quadrature source on the follower pins
// Assumes: requests spaced at least 4 clocks apart
// Notes:   pins hold their level until the next request
`timescale 1ns/10ps
`default_nettype none
module prf_quad_src (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // one forward count per request
    input  wire logic step,
    // encoder pins
    output logic      pin_a,
    output logic      pin_b
);
    logic [1:0] ph_ff;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            ph_ff <= 2'h0;
        else if (step)
            ph_ff <= ph_ff + 2'h1;
    end
    // gray order: only one pin changes per count
    assign pin_a = ph_ff[1];
    assign pin_b = ph_ff[1] ^ ph_ff[0];
endmodule : prf_quad_src
`default_nettype wire

// file: verification/prf_follower_tb_top.sv
// Purpose: bench for prf_follower
// Assumes: the bus master waits for waitrequest low, however long that takes
// Notes:   counts checked as deltas, except the first primary read and the secondary count; the follower count ignores encoder sense, the primary count does not
`timescale 1ns/10ps
`default_nettype none
module prf_follower_tb_top;
    import prf_pkg::*;
    logic        clk = 0, arst_n = 0, rd = 0, wr = 0, cs = 0, qs = 0, wq, ps, pd, irq, qa, qb;
    logic [7:0]  ad = 8'h00;
    logic [31:0] wd = 32'h0, rdat, q, f0, p0;
    logic [5:0]  io_out, io_oe;
    int          fail_count = 0, comparisons = 0, cyc = 0, pc = 0, sc = 0;
    always #5 clk = ~clk;
    prf_follower DUT (.clk(clk), .arst_n(arst_n), .avs_address(ad), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wq), .core_step(cs),
        .core_dir(1'b0), .prim_step(ps), .prim_dir(pd), .io_in({qb, qa, qb, qa, qb, qa}), .io_out(io_out),
        .io_oe(io_oe), .irq(irq));
    prf_quad_src src (.clk(clk), .arst_n(arst_n), .step(qs), .pin_a(qa), .pin_b(qb));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        ad <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        // look at waitrequest where it has settled; the next rising edge completes the transfer
        do @(negedge clk); while (wq !== 1'b0);
        q = rdat;
        @(posedge clk);
        rd <= 0;
        wr <= 0;
        @(posedge clk);
    endtask : acc
    task automatic steps(input int n);
        repeat (n) begin
            qs <= 1;
            @(posedge clk);
            qs <= 0;
            repeat (5) @(posedge clk);
        end
        repeat (10) @(posedge clk);
    endtask : steps
    task automatic ratio(input logic [31:0] fac, input logic neg);
        logic [31:0] e;
        int          n0;
        acc(1, OFS_HALF_FACTOR, fac);
        acc(0, OFS_FOLLOW_CNT, 0);
        f0 = q;
        acc(0, OFS_PRIM_CNT, 0);
        p0 = q;
        n0 = pc;
        steps(8);
        acc(0, OFS_FOLLOW_CNT, 0);
        f0 = q - f0;
        acc(0, OFS_PRIM_CNT, 0);
        p0 = q - p0;
        // eight input counts at a half give four steps, downward for a negative factor
        e = neg ? 32'hfffffffc : 32'h4;
        chk(f0[31] ? -f0 : f0, 32'h8);
        chk(p0, e);
        chk(32'(pc - n0), e);
    endtask : ratio
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            fail_count++;
            finish_test;
        end
    end
    // watch the step outputs where they have settled
    always @(negedge clk) begin
        if (ps)
            pc = pd ? pc - 1 : pc + 1;
        if (io_out[2])
            sc++;
    end
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1;
        @(posedge clk);
        acc(0, OFS_CTRL, 0);
        chk(q, 0);
        acc(0, OFS_HALF_FACTOR, 0);
        chk(q, 0);
        acc(1, OFS_IO_SETUP, 32'h1100030d);
        acc(1, OFS_IO_SETUP, 32'h1100040e);
        acc(1, OFS_CTRL, 1);
        steps(4);
        acc(0, OFS_PRIM_CNT, 0);
        chk(q, 0);
        acc(1, OFS_IRQ_ENABLE, 1);
        acc(1, OFS_HALF_FACTOR, 32'h00010000);
        acc(0, OFS_ERR_CODE, 0);
        chk(q, 32'h232c);
        chk({31'h0, irq}, 1);
        acc(1, OFS_HALF_FACTOR, 32'hffff0000);
        acc(0, OFS_HALF_FACTOR, 0);
        chk(q, 0);
        acc(1, OFS_IRQ_CLEAR, 1);
        chk({31'h0, irq}, 0);
        ratio(32'h00008000, 0);
        ratio(32'hffff8000, 1);
        // move the follower to pair 15/16: the third counter must see every raw count
        acc(1, OFS_IO_SETUP, 32'h0100030d);
        acc(1, OFS_IO_SETUP, 32'h1100050f);
        acc(1, OFS_IO_SETUP, 32'h11000610);
        acc(0, OFS_ALT_CNT, 0);
        p0 = q;
        steps(4);
        acc(0, OFS_ALT_CNT, 0);
        chk(q - p0, 32'h4);
        // then to pair 17/18: accepted, but the third counter stays put
        acc(1, OFS_IO_SETUP, 32'h0100050f);
        acc(1, OFS_IO_SETUP, 32'h11000711);
        acc(1, OFS_IO_SETUP, 32'h11000812);
        acc(0, OFS_ALT_CNT, 0);
        p0 = q;
        acc(0, OFS_FOLLOW_CNT, 0);
        f0 = q;
        steps(4);
        acc(0, OFS_ALT_CNT, 0);
        chk(q, p0);
        acc(0, OFS_FOLLOW_CNT, 0);
        f0 = q - f0;
        chk(f0[31] ? -f0 : f0, 32'h4);
        acc(1, OFS_IO_SETUP, 32'h1200050f);
        acc(1, OFS_IO_SETUP, 32'h12000610);
        acc(1, OFS_GEAR_FACTOR, 32'h00008000);
        acc(1, OFS_CTRL, 2);
        chk({26'h0, io_oe}, 32'h0c);
        repeat (8) begin
            cs <= 1;
            @(posedge clk);
            cs <= 0;
            @(posedge clk);
        end
        repeat (5) @(posedge clk);
        acc(0, OFS_SEC_CNT, 0);
        chk(q, 4);
        chk(sc, 4);
        acc(0, 8'h40, 0);
        chk(q, 0);
        finish_test;
    end
endmodule : prf_follower_tb_top
`default_nettype wire
